// >>> common/gpfm_pkg.sv
/*
 pin-function map package: port D register offsets, reset values,
 pin-select field layout and test-access state encoding.
 assumes a 32-bit apb slave with word-aligned registers.
*/
`default_nettype none
package gpfm_pkg;
   // register indices; byte address is four times the index
   localparam logic [3:0] GPFM_IDX_PULLUP   = 4'h0;
   localparam logic [3:0] GPFM_IDX_DATA     = 4'h1;
   localparam logic [3:0] GPFM_IDX_DIR      = 4'h2;
   localparam logic [3:0] GPFM_IDX_PEREN    = 4'h3;
   localparam logic [3:0] GPFM_IDX_IASSERT  = 4'h4;
   localparam logic [3:0] GPFM_IDX_IEN      = 4'h5;
   localparam logic [3:0] GPFM_IDX_IPOL     = 4'h6;
   localparam logic [3:0] GPFM_IDX_IPEND    = 4'h7;
   localparam logic [3:0] GPFM_IDX_IEDGE    = 4'h8;
   localparam logic [3:0] GPFM_IDX_PUSHPULL = 4'h9;
   localparam logic [3:0] GPFM_IDX_RAW      = 4'hA;
   localparam logic [3:0] GPFM_IDX_PINSEL   = 4'hB;
   localparam logic [3:0] GPFM_IDX_PORTB    = 4'hC;
   localparam logic [3:0] GPFM_IDX_PORTC    = 4'hD;
   localparam logic [3:0] GPFM_IDX_EXTERNAL_CLOCK_INPUT    = 4'hE;
   // reset values of the port B, C and D registers
   localparam logic [3:0] GPFM_RST_ONES     = 4'hF;
   localparam logic [3:0] GPFM_RST_ZERO     = 4'h0;
   localparam logic [7:0] GPFM_RST_PORTC_AN = 8'hFF;
   localparam logic [7:0] GPFM_RST_BYTE0    = 8'h00;
   // pin-select bit for each upper port B pin (bit n selects pin n)
   localparam int GPFM_PINSEL_W = 8;
   // tms-high edges that force the test-access reset state
   localparam int GPFM_TMS_RESET_EDGES = 5;
   typedef enum logic [3:0] {
      GPFM_TAP_RESET, GPFM_TAP_IDLE, GPFM_TAP_SEL_DR, GPFM_TAP_CAP_DR,
      GPFM_TAP_SHIFT_DR, GPFM_TAP_EX1_DR, GPFM_TAP_PAUSE_DR,
      GPFM_TAP_EX2_DR, GPFM_TAP_UPD_DR, GPFM_TAP_SEL_IR, GPFM_TAP_CAP_IR,
      GPFM_TAP_SHIFT_IR, GPFM_TAP_EX1_IR, GPFM_TAP_PAUSE_IR,
      GPFM_TAP_EX2_IR, GPFM_TAP_UPD_IR
   } gpfm_tap_e;
endpackage : gpfm_pkg
`default_nettype wire

// >>> dv/gpfm_pin_map_bench.sv
/*
 bench for the pin-function map: apb accesses compared with a register
 model, port B/C function outputs and test-access resets.
 assumes gpfm_tap_tester drives the port D pins.
*/
`timescale 1ns/1ps
`default_nettype none
module gpfm_pin_map_bench;
   import gpfm_pkg::*;
   logic        i_mclk, i_rstn, i_psel, i_penable, i_pwrite;
   logic [11:0] i_paddr;
   logic [31:0] i_pwdata, o_prdata, rd;
   logic        o_pready, o_pslverr, o_tap_in_reset, o_clk_en, er;
   logic [3:0]  pins, o_pd_out, o_pd_oe, o_pd_pu, o_tap_state, o_pd_irq;
   logic [7:0]  o_pb_en, o_pb_sel, o_pc_an;
   logic [31:0] regs [16];
   int          fails, n_tests, cyc;

   gpfm_pin_map i_gpfm_pin_map (.i_mclk(i_mclk), .i_rstn(i_rstn),
      .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
      .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
      .o_pready(o_pready), .o_pslverr(o_pslverr), .i_portd_pin(pins),
      .o_portd_out(o_pd_out), .o_portd_oe(o_pd_oe),
      .o_portd_pullup(o_pd_pu), .o_tap_state(o_tap_state),
      .o_tap_in_reset(o_tap_in_reset), .o_portb_periph_en(o_pb_en),
      .o_portb_alt_sel(o_pb_sel), .o_external_clock_input_en(o_clk_en),
      .o_portc_analog_en(o_pc_an), .o_portd_irq(o_pd_irq));
   gpfm_tap_tester i_gpfm_tap_tester (.i_mclk(i_mclk), .o_pins(pins));

   initial begin
      i_mclk = 1'b0;
      forever #5 i_mclk = ~i_mclk;
   end
   always @(posedge i_mclk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         end_sim();
      end
   end

   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : end_sim

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         $display("[ERR] %s expected %h seen %h", nm, e, g);
         fails++;
      end
   endtask : chk

   // model reset: only pull-up, peripheral-enable, push-pull and analog default are ones
   task automatic do_reset;
      i_rstn <= 1'b0;
      repeat (10) @(posedge i_mclk);
      i_rstn <= 1'b1;
      foreach (regs[i]) regs[i] = 32'h0;
      regs[0]  = 32'hF;
      regs[3]  = 32'hF;
      regs[9]  = 32'hF;
      regs[13] = 32'hFF;
   endtask : do_reset

   // one apb transfer; the leading edge keeps psel from double writes
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge i_mclk);
      i_psel    <= 1'b1;
      i_penable <= 1'b0;
      i_pwrite  <= wr;
      i_paddr   <= a;
      i_pwdata  <= wd;
      @(posedge i_mclk);
      i_penable <= 1'b1;
      do begin
         @(posedge i_mclk);
         n++;
      end while (o_pready !== 1'b1 && n < 50);
      if (n >= 50)
         fails++;
      rd = o_prdata;
      er = o_pslverr;
      i_psel    <= 1'b0;
      i_penable <= 1'b0;
   endtask : apb

   // pending has no stored state: assert and edge gated by enable
   task automatic rdchk(input int i);
      logic [31:0] e;
      e = (i == 10) ? {28'h0, pins} :
          (i == 7) ? (regs[4] | regs[8]) & regs[5] : regs[i];
      apb(1'b0, 12'(i * 4), 32'h0);
      chk($sformatf("reg%0d", i), e, rd);
      chk("slverr", 32'h0, {31'h0, er});
   endtask : rdchk

   task automatic tap_walk(input logic [3:0] t, input int n);
      for (int k = 0; k < n; k++)
         i_gpfm_tap_tester.step(t[k]);
   endtask : tap_walk

   initial begin
      logic [31:0] wd;
      i_rstn = 1'b0;
      i_psel = 1'b0;
      i_penable = 1'b0;
      i_pwrite = 1'b0;
      i_paddr = 12'h0;
      i_pwdata = 32'h0;
      void'($urandom(32'hF9807FD5));
      do_reset();
      @(posedge i_mclk);
      chk("tap_rst", 32'h1, {31'h0, o_tap_in_reset});
      chk("analog", 32'hFF, {24'h0, o_pc_an});
      chk("pb_en", 32'h0, {24'h0, o_pb_en});
      chk("pd_oe", 32'h0, {28'h0, o_pd_oe});
      chk("pd_irq", 32'h0, {28'h0, o_pd_irq});
      for (int i = 0; i < 15; i++) rdchk(i);
      for (int i = 0; i < 15; i++) begin
         wd = $urandom;
         apb(1'b1, 12'(i * 4), wd);
         if (i != 7 && i != 8 && i != 10)
            regs[i] = wd & (i < 11 ? 32'hF : i == 14 ? 32'h1 : 32'hFF);
         rdchk(i);
      end
      chk("pb_sel", regs[11], {24'h0, o_pb_sel});
      chk("pb_en", regs[12], {24'h0, o_pb_en});
      chk("clk_in", regs[14], {31'h0, o_clk_en});
      chk("analog", regs[13], {24'h0, o_pc_an});
      chk("pullup", regs[0], {28'h0, o_pd_pu});
      chk("pd_out", regs[1] & ~regs[3] & 32'hF, {28'h0, o_pd_out});
      chk("pd_irq", (regs[4] | regs[8]) & regs[5], {28'h0, o_pd_irq});
      apb(1'b0, 12'h040, 32'h0);
      chk("unmapped_rd", 32'h1, {31'h0, er});
      chk("unmapped_rd_data", 32'h0, rd);
      apb(1'b1, 12'h03C, 32'hFFFF);
      chk("unmapped_wr", 32'h1, {31'h0, er});
      apb(1'b0, 12'h001, 32'h0);
      chk("misaligned", 32'h1, {31'h0, er});
      chk("misaligned_rd", 32'h0, rd);
      apb(1'b1, 12'(GPFM_IDX_PEREN * 4), 32'hF);
      regs[3] = 32'hF;
      tap_walk(4'b0010, 4);
      chk("state", 32'(GPFM_TAP_SHIFT_DR), {28'h0, o_tap_state});
      chk("pd_oe_shift", 32'h2, {28'h0, o_pd_oe});
      tap_walk(4'b1111, 4);
      chk("tap_rst", 32'h0, {31'h0, o_tap_in_reset});
      chk("state", 32'(GPFM_TAP_SEL_IR), {28'h0, o_tap_state});
      tap_walk(4'b0001, 1);
      chk("tap_rst", 32'h1, {31'h0, o_tap_in_reset});
      rdchk(10);
      i_gpfm_tap_tester.hp = 9;
      tap_walk(4'b0010, 4);
      chk("tap_rst", 32'h0, {31'h0, o_tap_in_reset});
      @(posedge i_mclk);
      i_rstn <= 1'b0;
      @(posedge i_mclk);
      @(posedge i_mclk);
      chk("tap_por", 32'h1, {31'h0, o_tap_in_reset});
      do_reset();
      @(posedge i_mclk);
      chk("pullup", 32'hF, {28'h0, o_pd_pu});
      rdchk(3);
      end_sim();
   end
endmodule : gpfm_pin_map_bench
`default_nettype wire

// >>> dv/gpfm_tap_tester.sv
/*
 far-side model of the port D pins: an external tester driving tdi,
 tck and tms, with tdo held high by the board pull-up at all times.
 assumes the bench calls step() from its main sequence.
*/
`timescale 1ns/1ps
`default_nettype none
module gpfm_tap_tester (
   // clock
   input  wire logic       i_mclk,
   // pins toward the device
   output logic      [3:0] o_pins
);
   logic tdi;
   logic tck;
   logic tms;
   int   hp = 6;
   // tdo line seen through the board pull-up only
   assign o_pins = {tms, tck, 1'b1, tdi};
   initial begin
      tms = 1'b1;
      tck = 1'b0;
      tdi = 1'b0;
   end
   // one tck period; tck idles low so no stray rise between steps
   task automatic step(input logic t);
      @(posedge i_mclk);
      tms <= t;
      tdi <= 1'($urandom);
      repeat (hp) @(posedge i_mclk);
      tck <= 1'b1;
      repeat (hp) @(posedge i_mclk);
      tck <= 1'b0;
      repeat (hp) @(posedge i_mclk);
   endtask : step
endmodule : gpfm_tap_tester
`default_nettype wire

// >>> rtl/gpfm_pin_map.sv
/*
 general purpose pin-function map: port D register set behind apb,
 upper port B alternate-function selection, port C analog defaults
 and the test-access state machine on the port D pins.
 assumes a zero-wait apb master on i_mclk and pins asynchronous to it.
*/
// Summary of operation
// - port B pins 3,4,5,7 reset to gpio; when enabled, a pin-select bit picks one of two alternate signals.
// - port C bits 3 and 7 keep register bits and, like the others, reset to analog input function.
// - power-on reset puts the test-access state machine in its reset state.
// - tms held high for five consecutive rising tck edges puts the state machine in reset.
// - there is no test-reset pin; only power-on reset or the tms sequence resets the state machine.
// - pull-up, peripheral-enable and push-pull bits reset to ones; the other port D registers reset to zero.
`timescale 1ns/1ps
`default_nettype none
module gpfm_pin_map
   import gpfm_pkg::*;
#(
   parameter int PD_W = 4
) (
   // clock and reset
   input  wire logic        i_mclk,
   input  wire logic        i_rstn,
   // apb slave
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [11:0] i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic      [31:0] o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   // port D pins
   input  wire logic [3:0]  i_portd_pin,
   output logic      [3:0]  o_portd_out,
   output logic      [3:0]  o_portd_oe,
   output logic      [3:0]  o_portd_pullup,
   // test-access port state
   output logic      [3:0]  o_tap_state,
   output logic             o_tap_in_reset,
   // port B upper-pin function controls
   output logic      [7:0]  o_portb_periph_en,
   output logic      [7:0]  o_portb_alt_sel,
   output logic             o_external_clock_input_en,
   // port C analog function
   output logic      [7:0]  o_portc_analog_en,
   // port D interrupt
   output logic      [3:0]  o_portd_irq
);
   // registers
   logic [3:0] pullup_q, data_q, dir_q, peren_q, iassert_q, ien_q;
   logic [3:0] ipol_q, iedge_q, pushpull_q;
   logic [7:0] pinsel_q, portb_q, portc_q;
   logic       external_clock_input_q;
   logic [31:0] prdata_q;
   logic        pready_q, pslverr_q;
   logic [3:0]  pin_s, pin_prev_q;
   // test-access
   gpfm_tap_e   tap_q, tap_d;
   logic        tck_prev_q, tck_rise, tap_rst_q;
   logic [2:0]  tms_cnt_q, tms_cnt_d;
   logic [3:0]  out_q, oe_q, pu_q;
   logic [3:0]  irq_q;

   gpfm_sync3 #(.W(4)) u_sync (
      .i_mclk  (i_mclk),
      .i_rstn  (i_rstn),
      .i_async (i_portd_pin),
      .o_sync  (pin_s)
   );

   // apb decode
   wire        acc     = i_psel & ~i_penable;
   wire        wr_en   = acc & i_pwrite;
   wire        rd_en   = acc & ~i_pwrite;
   wire [3:0]  idx     = i_paddr[5:2];
   wire        aligned = (i_paddr[1:0] == 2'h0) && (i_paddr[11:6] == '0);
   wire        mapped  = aligned && (idx <= GPFM_IDX_EXTERNAL_CLOCK_INPUT);
   wire [3:0]  wd      = i_pwdata[3:0];
   wire        wr_hit  = wr_en & mapped;

   // tck edge and tms level from synchronised pins
   wire        tck_s   = pin_s[2];
   wire        tms_s   = pin_s[3];
   assign tck_rise = tck_s & ~tck_prev_q;

   // edge events on port D pins per selected polarity
   wire [3:0]  rise    = pin_s & ~pin_prev_q;
   wire [3:0]  fall    = ~pin_s & pin_prev_q;
   wire [3:0]  edge_ev = (ipol_q & fall) | (~ipol_q & rise);
   wire [3:0]  iedge_clr = (wr_hit && idx == GPFM_IDX_IEDGE) ? wd : 4'h0;
   // set wins over a same-cycle clear
   wire [3:0]  iedge_d = (iedge_q & ~iedge_clr) | (edge_ev & ien_q);
   wire [3:0]  ipend   = (iedge_q | iassert_q) & ien_q;

   // read mux; upper bits are zero
   logic [15:0] rd_val;
   always_comb begin
      rd_val = 16'h0000;
      unique case (idx)
         GPFM_IDX_PULLUP:   rd_val = {12'h000, pullup_q};
         GPFM_IDX_DATA:     rd_val = {12'h000, data_q};
         GPFM_IDX_DIR:      rd_val = {12'h000, dir_q};
         GPFM_IDX_PEREN:    rd_val = {12'h000, peren_q};
         GPFM_IDX_IASSERT:  rd_val = {12'h000, iassert_q};
         GPFM_IDX_IEN:      rd_val = {12'h000, ien_q};
         GPFM_IDX_IPOL:     rd_val = {12'h000, ipol_q};
         GPFM_IDX_IPEND:    rd_val = {12'h000, ipend};
         GPFM_IDX_IEDGE:    rd_val = {12'h000, iedge_q};
         GPFM_IDX_PUSHPULL: rd_val = {12'h000, pushpull_q};
         GPFM_IDX_RAW:      rd_val = {12'h000, pin_s};
         GPFM_IDX_PINSEL:   rd_val = {8'h00, pinsel_q};
         GPFM_IDX_PORTB:    rd_val = {8'h00, portb_q};
         GPFM_IDX_PORTC:    rd_val = {8'h00, portc_q};
         GPFM_IDX_EXTERNAL_CLOCK_INPUT:    rd_val = {15'h0000, external_clock_input_q};
         default:           rd_val = 16'h0000;
      endcase
   end

   // tap next state; tms high walks toward reset from any state
   always_comb begin
      tap_d = tap_q;
      unique case (tap_q)
         GPFM_TAP_RESET:    tap_d = tms_s ? GPFM_TAP_RESET : GPFM_TAP_IDLE;
         GPFM_TAP_IDLE:     tap_d = tms_s ? GPFM_TAP_SEL_DR : GPFM_TAP_IDLE;
         GPFM_TAP_SEL_DR:   tap_d = tms_s ? GPFM_TAP_SEL_IR : GPFM_TAP_CAP_DR;
         GPFM_TAP_CAP_DR:   tap_d = tms_s ? GPFM_TAP_EX1_DR
                                          : GPFM_TAP_SHIFT_DR;
         GPFM_TAP_SHIFT_DR: tap_d = tms_s ? GPFM_TAP_EX1_DR
                                          : GPFM_TAP_SHIFT_DR;
         GPFM_TAP_EX1_DR:   tap_d = tms_s ? GPFM_TAP_UPD_DR
                                          : GPFM_TAP_PAUSE_DR;
         GPFM_TAP_PAUSE_DR: tap_d = tms_s ? GPFM_TAP_EX2_DR
                                          : GPFM_TAP_PAUSE_DR;
         GPFM_TAP_EX2_DR:   tap_d = tms_s ? GPFM_TAP_UPD_DR
                                          : GPFM_TAP_SHIFT_DR;
         GPFM_TAP_UPD_DR:   tap_d = tms_s ? GPFM_TAP_SEL_DR : GPFM_TAP_IDLE;
         GPFM_TAP_SEL_IR:   tap_d = tms_s ? GPFM_TAP_RESET : GPFM_TAP_CAP_IR;
         GPFM_TAP_CAP_IR:   tap_d = tms_s ? GPFM_TAP_EX1_IR
                                          : GPFM_TAP_SHIFT_IR;
         GPFM_TAP_SHIFT_IR: tap_d = tms_s ? GPFM_TAP_EX1_IR
                                          : GPFM_TAP_SHIFT_IR;
         GPFM_TAP_EX1_IR:   tap_d = tms_s ? GPFM_TAP_UPD_IR
                                          : GPFM_TAP_PAUSE_IR;
         GPFM_TAP_PAUSE_IR: tap_d = tms_s ? GPFM_TAP_EX2_IR
                                          : GPFM_TAP_PAUSE_IR;
         GPFM_TAP_EX2_IR:   tap_d = tms_s ? GPFM_TAP_UPD_IR
                                          : GPFM_TAP_SHIFT_IR;
         GPFM_TAP_UPD_IR:   tap_d = tms_s ? GPFM_TAP_SEL_DR : GPFM_TAP_IDLE;
      endcase
      // belt and braces: explicit count forces reset after five highs
      if (tms_cnt_d == 3'(GPFM_TMS_RESET_EDGES))
         tap_d = GPFM_TAP_RESET;
   end

   always_comb begin
      tms_cnt_d = tms_cnt_q;
      if (tck_rise) begin
         if (!tms_s)
            tms_cnt_d = 3'h0;
         else if (tms_cnt_q != 3'(GPFM_TMS_RESET_EDGES))
            tms_cnt_d = tms_cnt_q + 3'h1;
      end
   end

   // port D pin drive: peripheral pins follow tap, else gpio regs
   wire [3:0] tap_oe  = {2'b00, (tap_q == GPFM_TAP_SHIFT_DR ||
                                 tap_q == GPFM_TAP_SHIFT_IR), 1'b0};
   wire [3:0] gp_oe   = dir_q & ~peren_q;
   wire [3:0] oe_d    = (peren_q & tap_oe) | gp_oe;
   wire [3:0] out_d   = data_q & ~peren_q;
   // open-drain bits only drive low
   wire [3:0] od_oe_d = oe_d & (pushpull_q | ~out_d);

   // apb and register file
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         pullup_q   <= GPFM_RST_ONES;
         peren_q    <= GPFM_RST_ONES;
         pushpull_q <= GPFM_RST_ONES;
         data_q     <= GPFM_RST_ZERO;
         dir_q      <= GPFM_RST_ZERO;
         iassert_q  <= GPFM_RST_ZERO;
         ien_q      <= GPFM_RST_ZERO;
         ipol_q     <= GPFM_RST_ZERO;
         iedge_q    <= GPFM_RST_ZERO;
         pinsel_q   <= GPFM_RST_BYTE0;
         portb_q    <= GPFM_RST_BYTE0;
         portc_q    <= GPFM_RST_PORTC_AN;
         external_clock_input_q    <= 1'b0;
         prdata_q   <= 32'h0000_0000;
         pready_q   <= 1'b0;
         pslverr_q  <= 1'b0;
      end else begin
         iedge_q   <= iedge_d;
         pready_q  <= acc;
         pslverr_q <= acc & ~mapped;
         prdata_q  <= (rd_en & mapped) ? {16'h0000, rd_val} : 32'h0;
         if (wr_hit) begin
            unique case (idx)
               GPFM_IDX_PULLUP:   pullup_q   <= wd;
               GPFM_IDX_DATA:     data_q     <= wd;
               GPFM_IDX_DIR:      dir_q      <= wd;
               GPFM_IDX_PEREN:    peren_q    <= wd;
               GPFM_IDX_IASSERT:  iassert_q  <= wd;
               GPFM_IDX_IEN:      ien_q      <= wd;
               GPFM_IDX_IPOL:     ipol_q     <= wd;
               GPFM_IDX_PUSHPULL: pushpull_q <= wd;
               GPFM_IDX_PINSEL:   pinsel_q   <= i_pwdata[7:0];
               GPFM_IDX_PORTB:    portb_q    <= i_pwdata[7:0];
               GPFM_IDX_PORTC:    portc_q    <= i_pwdata[7:0];
               GPFM_IDX_EXTERNAL_CLOCK_INPUT:    external_clock_input_q    <= i_pwdata[0];
               default:           ;
            endcase
         end
      end
   end

   // tap, pins and outputs; no test-reset input exists
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         tap_q      <= GPFM_TAP_RESET;
         tap_rst_q  <= 1'b1;
         tms_cnt_q  <= 3'h0;
         tck_prev_q <= 1'b0;
         pin_prev_q <= 4'h0;
         out_q      <= 4'h0;
         oe_q       <= 4'h0;
         pu_q       <= GPFM_RST_ONES;
         irq_q      <= 4'h0;
      end else begin
         tck_prev_q <= tck_s;
         pin_prev_q <= pin_s;
         tms_cnt_q  <= tms_cnt_d;
         if (tck_rise) begin
            tap_q     <= tap_d;
            tap_rst_q <= (tap_d == GPFM_TAP_RESET);
         end
         out_q <= out_d;
         oe_q  <= od_oe_d;
         pu_q  <= pullup_q;
         irq_q <= ipend;
      end
   end

   assign o_prdata       = prdata_q;
   assign o_pready       = pready_q;
   assign o_pslverr      = pslverr_q;
   assign o_portd_out    = out_q;
   assign o_portd_oe     = oe_q;
   assign o_portd_pullup = pu_q;
   assign o_tap_state    = tap_q;
   assign o_tap_in_reset = tap_rst_q;
   // pins 3,4,5,7 gpio unless enabled; pin 6 rxd/sda by same field
   assign o_portb_periph_en = portb_q;
   assign o_portb_alt_sel   = pinsel_q;
   assign o_external_clock_input_en = external_clock_input_q;
   assign o_portc_analog_en = portc_q;
   assign o_portd_irq       = irq_q;

   // assertions
   property p_tap_por;
      @(posedge i_mclk) $rose(i_rstn) |-> tap_q == GPFM_TAP_RESET;
   endproperty
   a_tap_por: assert property (p_tap_por)
      else $error("tap not in reset after power-on");

   sequence s_tms_hi_edge;
      tck_rise && tms_s && tms_cnt_q == 3'h4;
   endsequence
   property p_tms_reset;
      @(posedge i_mclk) disable iff (!i_rstn)
         s_tms_hi_edge |=> tap_q == GPFM_TAP_RESET;
   endproperty
   a_tms_reset: assert property (p_tms_reset)
      else $error("five tms highs did not reset tap");

   property p_no_other_reset;
      @(posedge i_mclk) disable iff (!i_rstn)
         (tap_q != GPFM_TAP_RESET && !tck_rise) |=>
            tap_q != GPFM_TAP_RESET;
   endproperty
   a_no_other_reset: assert property (p_no_other_reset)
      else $error("tap reset without tck or power-on");

   property p_pd_reset;
      @(posedge i_mclk) $rose(i_rstn) |->
         pullup_q == 4'hF && peren_q == 4'hF && pushpull_q == 4'hF &&
         data_q == 4'h0 && dir_q == 4'h0 && ien_q == 4'h0;
   endproperty
   a_pd_reset: assert property (p_pd_reset)
      else $error("port d reset values wrong");

   property p_upper_zero;
      @(posedge i_mclk) disable iff (!i_rstn)
         (rd_en && mapped && idx <= GPFM_IDX_RAW) |=>
            o_prdata[31:4] == 28'h0 && o_pready;
   endproperty
   a_upper_zero: assert property (p_upper_zero)
      else $error("port d upper bits not zero");

   property p_portb_gpio;
      @(posedge i_mclk) $rose(i_rstn) |->
         o_portb_periph_en == 8'h00 && o_portb_alt_sel == 8'h00;
   endproperty
   a_portb_gpio: assert property (p_portb_gpio)
      else $error("port b not gpio after reset");

   property p_external_clock_input_sep;
      @(posedge i_mclk) disable iff (!i_rstn)
         (wr_hit && idx == GPFM_IDX_PINSEL) |=>
            $stable(o_external_clock_input_en);
   endproperty
   a_external_clock_input_sep: assert property (p_external_clock_input_sep)
      else $error("pin-select changed clock input enable");

   property p_portc_an;
      @(posedge i_mclk) $rose(i_rstn) |-> o_portc_analog_en == 8'hFF;
   endproperty
   a_portc_an: assert property (p_portc_an)
      else $error("port c not analog after reset");
endmodule : gpfm_pin_map
`default_nettype wire

// >>> rtl/gpfm_sync3.sv
/*
 three-flop synchroniser for a vector of pin inputs; the output only
 changes when the second and third stages agree.
 assumes inputs asynchronous to i_mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module gpfm_sync3 #(
   parameter int W = 4
) (
   // clock and reset
   input  wire logic         i_mclk,
   input  wire logic         i_rstn,
   // data
   input  wire logic [W-1:0] i_async,
   output logic      [W-1:0] o_sync
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;
   logic [W-1:0] out_d;
   logic [W-1:0] out_q;

   // first stage feeds only the second
   assign out_d  = (s2_q == s3_q) ? s3_q : out_q;
   assign o_sync = out_q;

   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         s1_q  <= '0;
         s2_q  <= '0;
         s3_q  <= '0;
         out_q <= '0;
      end else begin
         s1_q  <= i_async;
         s2_q  <= s1_q;
         s3_q  <= s2_q;
         out_q <= out_d;
      end
   end
endmodule : gpfm_sync3
`default_nettype wire
